// ===== remote_alarm_menu_relay_ctrl.sv
// Purpose: program-mode menu, value editing, relay alarm logic and loop simulation
// Assumes: switch inputs debounced; status values and concentration supplied by the sensor side
// Notes: all long counts are top parameters so a simulation can shorten them
module remote_alarm_menu_relay_ctrl #(
  parameter int unsigned HOLD_CYC = menu_relay_pkg::HOLD_CYC,
  parameter int unsigned IDLE_CYC = menu_relay_pkg::IDLE_CYC,
  parameter int unsigned STEP_CYC = menu_relay_pkg::STEP_CYC,
  parameter int unsigned SAVED_CYC = menu_relay_pkg::SAVED_CYC
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic first_magnet_switch_i,
  input wire logic second_magnet_switch_i,
  input wire logic arrow_prompt_i,
  input wire logic [6:0] concentration_i,
  input wire logic sensor_fault_i,
  input wire logic relay_reset_i,
  input wire logic [7:0] status_value_i,
  output logic [3:0] status_index_o,
  output logic program_mode_o,
  output logic [2:0] menu_item_o,
  output logic [2:0] message_o,
  output logic [2:0] setup_step_o,
  output logic [7:0] display_value_o,
  output logic [6:0] span_level_o,
  output logic [6:0] slave_address_o,
  output logic [6:0] sensor_address_o,
  output logic [6:0] alarm_one_threshold_o,
  output logic [6:0] alarm_two_threshold_o,
  output logic [5:0] relay_cfg_o,
  output logic alarm_one_relay_o,
  output logic alarm_two_relay_o,
  output logic fault_relay_o,
  output logic alarm_one_active_o,
  output logic alarm_two_active_o,
  output logic fault_active_o,
  output logic sim_active_o,
  output logic [6:0] sim_percent_o
);
  typedef enum logic [1:0] {PRESS_NONE = 2'h0, PRESS_TAP = 2'h1, PRESS_HOLD = 2'h2} press_t;

  menu_relay_pkg::state_t state_r;
  menu_relay_pkg::item_t item_r;
  menu_relay_pkg::step_t step_r;
  logic [31:0] hold_cnt_r;
  logic [31:0] idle_cnt_r;
  logic [31:0] tmr_r;
  logic [31:0] saved_cnt_r;
  logic hold_fired_r;
  logic first_r, second_r, arrow_seen_r;
  logic tap1, tap2, hold1, hold_any, hold2_entry;
  logic [6:0] edit_r;
  logic yes_r;
  logic [3:0] status_idx_r;
  logic [6:0] span_r, addr_r, thr1_r, thr2_r;
  logic rise1_r, rise2_r, latch1_r, latch2_r, latchf_r, en1_r, en2_r, enf_r;
  logic cond1, cond2, act1_r, act2_r, actf_r;
  logic [6:0] sim_pct_r;
  logic sim_down_r;
  logic any_sw;

  function automatic logic [6:0] bump(input logic [6:0] v, input logic up, input logic [6:0] lo,
                                      input logic [6:0] hi);
    logic [6:0] r;
    r = v;
    if (up && v < hi) r = v + 7'h01;
    else if (!up && v > lo) r = v - 7'h01;
    return r;
  endfunction

  // one table of edit limits keeps the swipe and the save paths in agreement
  function automatic logic [6:0] limit_of(input menu_relay_pkg::item_t i, input logic top);
    case (i)
      menu_relay_pkg::ITEM_SPAN: limit_of = top ? menu_relay_pkg::SPAN_MAX : menu_relay_pkg::SPAN_MIN;
      menu_relay_pkg::ITEM_ADDR: limit_of = top ? menu_relay_pkg::ADDR_MAX : menu_relay_pkg::ADDR_MIN;
      default: limit_of = top ? menu_relay_pkg::THR_MAX : menu_relay_pkg::THR_MIN;
    endcase
  endfunction

  function automatic logic [6:0] clampv(input logic [6:0] v, input menu_relay_pkg::item_t i);
    return (v < limit_of(i, 1'b0)) ? limit_of(i, 1'b0) : ((v > limit_of(i, 1'b1)) ? limit_of(i, 1'b1) : v);
  endfunction

  function automatic menu_relay_pkg::item_t next_item(input menu_relay_pkg::item_t i);
    case (i)
      menu_relay_pkg::ITEM_STATUS: next_item = menu_relay_pkg::ITEM_SPAN;
      menu_relay_pkg::ITEM_SPAN: next_item = menu_relay_pkg::ITEM_ADDR;
      menu_relay_pkg::ITEM_ADDR: next_item = menu_relay_pkg::ITEM_ALARM_ONE_RELAY;
      menu_relay_pkg::ITEM_ALARM_ONE_RELAY: next_item = menu_relay_pkg::ITEM_ALARM_TWO_RELAY;
      menu_relay_pkg::ITEM_ALARM_TWO_RELAY: next_item = menu_relay_pkg::ITEM_FAULT;
      menu_relay_pkg::ITEM_FAULT: next_item = menu_relay_pkg::ITEM_SIM;
      default: next_item = menu_relay_pkg::ITEM_STATUS;
    endcase
  endfunction

  assign any_sw = first_magnet_switch_i | second_magnet_switch_i;

  // hold timing: the count starts once the arrow prompt shows; a hold fires once per press
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_r <= 1'b0;
      second_r <= 1'b0;
      hold_cnt_r <= '0;
      hold_fired_r <= 1'b0;
      arrow_seen_r <= 1'b0;
    end else begin
      first_r <= first_magnet_switch_i;
      second_r <= second_magnet_switch_i;
      if (!any_sw) begin
        hold_cnt_r <= '0;
        hold_fired_r <= 1'b0;
        arrow_seen_r <= 1'b0;
      end else begin
        if (arrow_prompt_i) arrow_seen_r <= 1'b1;
        if ((arrow_seen_r || arrow_prompt_i) && hold_cnt_r < HOLD_CYC) hold_cnt_r <= hold_cnt_r + 32'd1;
        if (hold_cnt_r == HOLD_CYC - 1) hold_fired_r <= 1'b1;
      end
    end
  end

  // a tap is a release before the hold fired; a hold fires on reaching the count
  assign hold_any = any_sw && (hold_cnt_r == HOLD_CYC - 1);
  assign hold1 = hold_any && first_magnet_switch_i;
  assign hold2_entry = hold_any && second_magnet_switch_i;
  assign tap1 = first_r && !first_magnet_switch_i && !hold_fired_r;
  assign tap2 = second_r && !second_magnet_switch_i && !hold_fired_r;

  // inactivity timer, not running in simulation
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) idle_cnt_r <= '0;
    else if (any_sw || state_r == menu_relay_pkg::ST_SIM || state_r == menu_relay_pkg::ST_NORMAL)
      idle_cnt_r <= '0;
    else if (idle_cnt_r < IDLE_CYC) idle_cnt_r <= idle_cnt_r + 32'd1;
  end

  // menu state machine
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= menu_relay_pkg::ST_NORMAL;
      item_r <= menu_relay_pkg::ITEM_STATUS;
      step_r <= menu_relay_pkg::STEP_LEVEL;
      edit_r <= '0;
      yes_r <= 1'b0;
      status_idx_r <= '0;
      tmr_r <= '0;
      saved_cnt_r <= '0;
      span_r <= menu_relay_pkg::SPAN_RST;
      addr_r <= menu_relay_pkg::ADDR_RST;
      thr1_r <= menu_relay_pkg::THR1_RST;
      thr2_r <= menu_relay_pkg::THR2_RST;
      rise1_r <= 1'b1;
      rise2_r <= 1'b1;
      latch1_r <= 1'b0;
      latch2_r <= 1'b0;
      latchf_r <= 1'b0;
      en1_r <= 1'b0;
      en2_r <= 1'b0;
      enf_r <= 1'b1;
    end else begin
      case (state_r)
        menu_relay_pkg::ST_NORMAL: begin
          if (hold2_entry) begin
            state_r <= menu_relay_pkg::ST_MENU;
            item_r <= menu_relay_pkg::ITEM_STATUS;
          end
        end
        menu_relay_pkg::ST_MENU: begin
          if (idle_cnt_r == IDLE_CYC) state_r <= menu_relay_pkg::ST_NORMAL;
          else if (hold_any) begin
            case (item_r)
              menu_relay_pkg::ITEM_STATUS: begin
                state_r <= menu_relay_pkg::ST_SCROLL;
                status_idx_r <= '0;
                tmr_r <= '0;
              end
              menu_relay_pkg::ITEM_SPAN: begin
                state_r <= menu_relay_pkg::ST_EDIT;
                edit_r <= span_r;
                step_r <= menu_relay_pkg::STEP_LEVEL;
              end
              menu_relay_pkg::ITEM_ADDR: begin
                state_r <= menu_relay_pkg::ST_EDIT;
                edit_r <= addr_r;
                step_r <= menu_relay_pkg::STEP_LEVEL;
              end
              menu_relay_pkg::ITEM_ALARM_ONE_RELAY: begin
                state_r <= menu_relay_pkg::ST_EDIT;
                edit_r <= thr1_r;
                step_r <= menu_relay_pkg::STEP_LEVEL;
              end
              menu_relay_pkg::ITEM_ALARM_TWO_RELAY: begin
                state_r <= menu_relay_pkg::ST_EDIT;
                edit_r <= thr2_r;
                step_r <= menu_relay_pkg::STEP_LEVEL;
              end
              menu_relay_pkg::ITEM_FAULT: begin
                state_r <= menu_relay_pkg::ST_EDIT;
                yes_r <= latchf_r;
                step_r <= menu_relay_pkg::STEP_LATCH;
              end
              default: begin
                state_r <= menu_relay_pkg::ST_SIM;
                tmr_r <= '0;
              end
            endcase
          end else if (tap1 || tap2) item_r <= next_item(item_r);
        end
        menu_relay_pkg::ST_SCROLL: begin
          // each status entry shows for one step period
          if (tmr_r == STEP_CYC - 1) begin
            tmr_r <= '0;
            if (status_idx_r == menu_relay_pkg::STATUS_LAST) state_r <= menu_relay_pkg::ST_MENU;
            else status_idx_r <= status_idx_r + 4'h1;
          end else tmr_r <= tmr_r + 32'd1;
        end
        menu_relay_pkg::ST_EDIT: begin
          if (step_r == menu_relay_pkg::STEP_LEVEL) begin
            // a second-switch swipe wins over a first-switch swipe in the same cycle
            if (tap1 || tap2) edit_r <= bump(edit_r, tap2, limit_of(item_r, 1'b0), limit_of(item_r, 1'b1));
            else if (hold_any) begin
              case (item_r)
                menu_relay_pkg::ITEM_SPAN: span_r <= clampv(edit_r, item_r);
                menu_relay_pkg::ITEM_ADDR: addr_r <= clampv(edit_r, item_r);
                menu_relay_pkg::ITEM_ALARM_ONE_RELAY: thr1_r <= clampv(edit_r, item_r);
                default: thr2_r <= clampv(edit_r, item_r);
              endcase
              state_r <= menu_relay_pkg::ST_SAVED;
              saved_cnt_r <= '0;
              yes_r <= (item_r == menu_relay_pkg::ITEM_ALARM_ONE_RELAY) ? rise1_r : rise2_r;
              step_r <= (item_r == menu_relay_pkg::ITEM_SPAN || item_r == menu_relay_pkg::ITEM_ADDR) ?
                        menu_relay_pkg::STEP_DONE : menu_relay_pkg::STEP_DIR;
            end
          end else begin
            // yes/no steps answer only the first switch
            if (tap1) yes_r <= !yes_r;
            else if (hold1) begin
              case (step_r)
                menu_relay_pkg::STEP_DIR: begin
                  if (item_r == menu_relay_pkg::ITEM_ALARM_ONE_RELAY) rise1_r <= yes_r;
                  else rise2_r <= yes_r;
                  yes_r <= (item_r == menu_relay_pkg::ITEM_ALARM_ONE_RELAY) ? latch1_r : latch2_r;
                  step_r <= menu_relay_pkg::STEP_LATCH;
                end
                menu_relay_pkg::STEP_LATCH: begin
                  if (item_r == menu_relay_pkg::ITEM_ALARM_ONE_RELAY) latch1_r <= yes_r;
                  else if (item_r == menu_relay_pkg::ITEM_ALARM_TWO_RELAY) latch2_r <= yes_r;
                  else latchf_r <= yes_r;
                  yes_r <= (item_r == menu_relay_pkg::ITEM_ALARM_ONE_RELAY) ? en1_r :
                           ((item_r == menu_relay_pkg::ITEM_ALARM_TWO_RELAY) ? en2_r : enf_r);
                  step_r <= menu_relay_pkg::STEP_ENERG;
                end
                default: begin
                  if (item_r == menu_relay_pkg::ITEM_ALARM_ONE_RELAY) en1_r <= yes_r;
                  else if (item_r == menu_relay_pkg::ITEM_ALARM_TWO_RELAY) en2_r <= yes_r;
                  else enf_r <= yes_r;
                  step_r <= menu_relay_pkg::STEP_DONE;
                end
              endcase
              state_r <= menu_relay_pkg::ST_SAVED;
              saved_cnt_r <= '0;
            end
          end
        end
        menu_relay_pkg::ST_SAVED: begin
          if (saved_cnt_r == SAVED_CYC - 1) begin
            state_r <= (step_r == menu_relay_pkg::STEP_DONE) ? menu_relay_pkg::ST_MENU : menu_relay_pkg::ST_EDIT;
          end else saved_cnt_r <= saved_cnt_r + 32'd1;
        end
        menu_relay_pkg::ST_SIM: begin
          if (hold_any) state_r <= menu_relay_pkg::ST_MENU;
          if (tmr_r == STEP_CYC - 1) tmr_r <= '0;
          else tmr_r <= tmr_r + 32'd1;
        end
        default: state_r <= menu_relay_pkg::ST_NORMAL;
      endcase
    end
  end

  // loop simulation ramp, bounces between 0 and 100 percent until stopped
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sim_pct_r <= '0;
      sim_down_r <= 1'b0;
    end else if (state_r != menu_relay_pkg::ST_SIM) begin
      sim_pct_r <= '0;
      sim_down_r <= 1'b0;
    end else if (tmr_r == STEP_CYC - 1) begin
      if (!sim_down_r) begin
        if (sim_pct_r == menu_relay_pkg::PCT_MAX - 7'h01) sim_down_r <= 1'b1;
        sim_pct_r <= sim_pct_r + 7'h01;
      end else begin
        if (sim_pct_r == 7'h01) sim_down_r <= 1'b0;
        sim_pct_r <= sim_pct_r - 7'h01;
      end
    end
  end

  assign cond1 = rise1_r ? (concentration_i >= thr1_r) : (concentration_i <= thr1_r);
  assign cond2 = rise2_r ? (concentration_i >= thr2_r) : (concentration_i <= thr2_r);

  // relay activity: latched relays hold until the condition is gone and reset is asserted
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act1_r <= 1'b0;
      act2_r <= 1'b0;
      actf_r <= 1'b0;
    end else begin
      act1_r <= cond1 || (latch1_r && act1_r && !relay_reset_i);
      act2_r <= cond2 || (latch2_r && act2_r && !relay_reset_i);
      actf_r <= sensor_fault_i || (latchf_r && actf_r && !relay_reset_i);
    end
  end

  // contact state: energized relays are held closed when idle, so power loss opens them
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alarm_one_relay_o <= 1'b0;
      alarm_two_relay_o <= 1'b0;
      fault_relay_o <= 1'b0;
    end else begin
      alarm_one_relay_o <= act1_r ^ en1_r;
      alarm_two_relay_o <= act2_r ^ en2_r;
      fault_relay_o <= actf_r ^ enf_r;
    end
  end

  // display value register
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) display_value_o <= '0;
    else if (state_r == menu_relay_pkg::ST_SCROLL) display_value_o <= status_value_i;
    else if (state_r == menu_relay_pkg::ST_SIM) display_value_o <= {1'b0, sim_pct_r};
    else if (step_r == menu_relay_pkg::STEP_LEVEL) display_value_o <= {1'b0, edit_r};
    else display_value_o <= {7'h00, yes_r};
  end

  always_comb begin
    case (state_r)
      menu_relay_pkg::ST_MENU: message_o = menu_relay_pkg::MSG_ITEM;
      menu_relay_pkg::ST_SCROLL: message_o = menu_relay_pkg::MSG_STATUS;
      menu_relay_pkg::ST_EDIT: message_o = (step_r == menu_relay_pkg::STEP_LEVEL) ?
                                           menu_relay_pkg::MSG_VALUE : menu_relay_pkg::MSG_YESNO;
      menu_relay_pkg::ST_SAVED: message_o = menu_relay_pkg::MSG_SAVED;
      menu_relay_pkg::ST_SIM: message_o = menu_relay_pkg::MSG_SIM;
      default: message_o = menu_relay_pkg::MSG_NONE;
    endcase
  end

  assign status_index_o = status_idx_r;
  assign program_mode_o = state_r != menu_relay_pkg::ST_NORMAL;
  assign menu_item_o = item_r;
  assign setup_step_o = step_r;
  assign span_level_o = span_r;
  assign slave_address_o = addr_r;
  assign sensor_address_o = menu_relay_pkg::SENSOR_ADDR;
  assign alarm_one_threshold_o = thr1_r;
  assign alarm_two_threshold_o = thr2_r;
  assign relay_cfg_o = {enf_r, latchf_r, en2_r, latch2_r, en1_r, latch1_r};
  assign alarm_one_active_o = act1_r;
  assign alarm_two_active_o = act2_r;
  assign fault_active_o = actf_r;
  assign sim_active_o = state_r == menu_relay_pkg::ST_SIM;
  assign sim_percent_o = sim_pct_r;
endmodule // remote_alarm_menu_relay_ctrl

// ===== menu_relay_pkg.sv
// Purpose: constants and types for the remote alarm menu and relay controller
// Assumes: 125 MHz mclk_i, switch inputs already debounced and synchronous
// Notes: times are kept in their own unit, cycle counts derive from the clock rate
// Functional notes
// - Second switch hold past arrow prompt plus 3 s enters status view.
// - Further 3 s hold in status view scrolls all status items, then returns.
// - Status list order: firmware, model, range, address, span ... fault settings.
// - Momentary hold advances menu item; 5 s without activity returns to normal; code returns only from the menu item list, never from an edit.
// - Span level held within 10 to 100 percent of range.
// - Edits show current value, second swipe up, first down, 3 s hold saves.
// - Slave address held in 0x01 to 0x7f, shown and edited in hex.
// - Own address independent of sensor; sensor must sit at address 01.
// - Alarm thresholds held within 1 to 95 percent of full scale.
// - Rising alarm asserts when concentration is at or above threshold.
// - Falling alarm asserts when concentration is at or below threshold.
// - Latching relay stays active after clear; non-latching follows the condition.
// - Energized relay keeps normally-open contact closed while not in alarm.
// - Alarm setup: threshold, direction, latching, energized; first swipe toggles, hold saves.
// - Fault setup offers only latching and energized steps.
// - Simulation ramps loop 4 to 20 mA in 1 percent steps each second, then down.
// - Simulation never times out; only a 3 s hold ends it to its menu item.
// - Simulation-active message shown continuously while simulation runs.
// - Menu order: status, span, address, alarm one, alarm two, fault, simulation.
package menu_relay_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HOLD_MS = 3000;
  localparam int unsigned IDLE_MS = 5000;
  localparam int unsigned STEP_MS = 1000;
  localparam int unsigned SAVED_MS = 1000;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_CYC = STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned SAVED_CYC = SAVED_MS * (CLK_HZ / 1000);
  localparam logic [6:0] SPAN_MIN = 7'h0a;
  localparam logic [6:0] SPAN_MAX = 7'h64;
  localparam logic [6:0] SPAN_RST = 7'h32;
  localparam logic [6:0] ADDR_MIN = 7'h01;
  localparam logic [6:0] ADDR_MAX = 7'h7f;
  localparam logic [6:0] ADDR_RST = 7'h01;
  localparam logic [6:0] SENSOR_ADDR = 7'h01;
  localparam logic [6:0] THR_MIN = 7'h01;
  localparam logic [6:0] THR_MAX = 7'h5f;
  localparam logic [6:0] THR1_RST = 7'h14;
  localparam logic [6:0] THR2_RST = 7'h28;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [3:0] STATUS_LAST = 4'hd;

  typedef enum logic [2:0] {
    ITEM_STATUS = 3'h0, ITEM_SPAN = 3'h1, ITEM_ADDR = 3'h3, ITEM_ALARM_ONE_RELAY = 3'h2,
    ITEM_ALARM_TWO_RELAY = 3'h6, ITEM_FAULT = 3'h7, ITEM_SIM = 3'h5
  } item_t;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'h0, ST_MENU = 4'h1, ST_SCROLL = 4'h3, ST_EDIT = 4'h2,
    ST_SAVED = 4'h6, ST_SIM = 4'h7
  } state_t;

  typedef enum logic [2:0] {
    STEP_LEVEL = 3'h0, STEP_DIR = 3'h1, STEP_LATCH = 3'h3, STEP_ENERG = 3'h2, STEP_DONE = 3'h6
  } step_t;

  // display codes for the message shown beside the value
  typedef enum logic [2:0] {
    MSG_NONE = 3'h0, MSG_ITEM = 3'h1, MSG_STATUS = 3'h2, MSG_VALUE = 3'h3,
    MSG_YESNO = 3'h4, MSG_SAVED = 3'h5, MSG_SIM = 3'h6
  } msg_t;
endpackage

// ===== operator_model.sv
// Purpose: far-side model: magnet operator prompt and attached sensor status source
// Assumes: prompt shows whenever a magnet sits over either switch
// Notes: status entries carry their own index so the scroll order shows up
module operator_model (
  input wire logic first_i,
  input wire logic second_i,
  input wire logic [3:0] status_index_i,
  input wire logic [6:0] sensor_address_i,
  output logic arrow_prompt_o,
  output logic [7:0] status_value_o,
  output logic comm_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign arrow_prompt_o = first_i | second_i;
  assign status_value_o = {4'ha, status_index_i};
  // the sensor answers only when configured at its fixed address
  assign comm_ok_o = (sensor_address_i == 7'h01);
endmodule // operator_model

// ===== menu_relay_asserts.sv
// Purpose: port-level checks of the menu and relay controller
// Assumes: single clock, active-low async reset
// Notes: relay direction is left to the bench
module menu_relay_asserts (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic first_magnet_switch_i,
  input wire logic second_magnet_switch_i,
  input wire logic relay_reset_i,
  input wire logic [3:0] status_index_o,
  input wire logic program_mode_o,
  input wire logic [2:0] message_o,
  input wire logic [6:0] span_level_o,
  input wire logic [6:0] slave_address_o,
  input wire logic [6:0] sensor_address_o,
  input wire logic [6:0] alarm_one_threshold_o,
  input wire logic [6:0] alarm_two_threshold_o,
  input wire logic [5:0] relay_cfg_o,
  input wire logic alarm_one_relay_o,
  input wire logic fault_relay_o,
  input wire logic alarm_one_active_o,
  input wire logic fault_active_o,
  input wire logic sim_active_o,
  input wire logic [6:0] sim_percent_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  a_sensor_addr: assert property (sensor_address_o == 7'h01)
    else $error("sensor address not 01");
  a_span_limits: assert property (span_level_o >= 7'h0a && span_level_o <= 7'h64)
    else $error("span level out of range");
  a_addr_limits: assert property (slave_address_o != 7'h00)
    else $error("slave address zero");
  a_thr_limits: assert property (alarm_one_threshold_o inside {[7'h01:7'h5f]} &&
    alarm_two_threshold_o inside {[7'h01:7'h5f]}) else $error("threshold out of range");
  a_sim_message: assert property (sim_active_o |-> message_o == 3'h6)
    else $error("simulation message missing");
  a_sim_no_timeout: assert property (sim_active_o && !first_magnet_switch_i && !second_magnet_switch_i
    && !$past(first_magnet_switch_i) && !$past(second_magnet_switch_i) |=> sim_active_o)
    else $error("simulation ended without hold");
  a_sim_ramp_step: assert property (sim_active_o && $past(sim_active_o) |-> sim_percent_o <= 7'h64 &&
    (sim_percent_o - $past(sim_percent_o)) inside {7'h00, 7'h01, 7'h7f}) else $error("ramp step wrong");
  a_scroll_order: assert property (message_o == 3'h2 && $past(message_o) == 3'h2 && $changed(status_index_o)
    |-> status_index_o == $past(status_index_o) + 4'h1 && status_index_o <= 4'hd) else $error("status order");
  a_entry_second: assert property (!program_mode_o && !second_magnet_switch_i
    && !$past(second_magnet_switch_i) |=> !program_mode_o) else $error("program mode without hold");
  a_latch_hold: assert property (relay_cfg_o[0] && alarm_one_active_o && !relay_reset_i
    |=> alarm_one_active_o) else $error("latched alarm dropped");
  a_contact_state: assert property ($past(resetn_i) |-> alarm_one_relay_o ==
    $past(alarm_one_active_o ^ relay_cfg_o[1]) && fault_relay_o == $past(fault_active_o ^ relay_cfg_o[5]))
    else $error("relay contact wrong");
  c_sim_top: cover property (sim_active_o && sim_percent_o == 7'h64);
  c_scroll_end: cover property (message_o == 3'h2 && status_index_o == 4'hd);
  c_latched: cover property (alarm_one_active_o && relay_cfg_o[0]);
endmodule // menu_relay_asserts
bind remote_alarm_menu_relay_ctrl menu_relay_asserts chk_i (.*);

// ===== remote_alarm_menu_relay_ctrl_test.sv
// Purpose: walk the menu, edits, relays and loop simulation through the switch inputs
// Assumes: shortened counts hold 20, idle 200, step 10, saved 5 cycles
// Notes: idle exceeds a full scroll
module remote_alarm_menu_relay_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int IDLE = 200;
  logic mclk_i = 1'b0, resetn_i = 1'b0, first_magnet_switch_i = 1'b0, second_magnet_switch_i = 1'b0;
  logic sensor_fault_i = 1'b0, relay_reset_i = 1'b0, arrow_prompt_i, comm_ok;
  logic [6:0] concentration_i = 7'h00;
  logic [7:0] status_value_i, display_value_o;
  logic [3:0] status_index_o, last;
  logic program_mode_o, alarm_one_relay_o, alarm_two_relay_o, fault_relay_o, alarm_one_active_o;
  logic alarm_two_active_o, fault_active_o, sim_active_o;
  logic [2:0] menu_item_o, message_o, setup_step_o;
  logic [6:0] span_level_o, slave_address_o, sensor_address_o, alarm_one_threshold_o, alarm_two_threshold_o;
  logic [6:0] sim_percent_o;
  logic [5:0] relay_cfg_o;
  int bad_count = 0, num_checks = 0, n;
  logic [2:0] items [7] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h0};
  remote_alarm_menu_relay_ctrl #(.HOLD_CYC(HOLD), .IDLE_CYC(IDLE), .STEP_CYC(10), .SAVED_CYC(5)) dut (.*);
  operator_model op (.first_i(first_magnet_switch_i), .second_i(second_magnet_switch_i),
    .status_index_i(status_index_o), .sensor_address_i(sensor_address_o), .arrow_prompt_o(arrow_prompt_i),
    .status_value_o(status_value_i), .comm_ok_o(comm_ok));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // magnet over the chosen switches for n cycles, then a pause longer than the saved message
  task automatic press(input logic a, input logic b, input int cyc);
    first_magnet_switch_i <= a;
    second_magnet_switch_i <= b;
    repeat (cyc) @(posedge mclk_i);
    first_magnet_switch_i <= 1'b0;
    second_magnet_switch_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic hold(input logic a, input logic b);
    press(a, b, HOLD + 4);
  endtask
  task automatic tap(input logic a, input logic b);
    press(a, b, 2);
  endtask
  task automatic go_item(input logic [2:0] item);
    for (int i = 0; i < 8 && menu_item_o !== item; i++) tap(1'b1, 1'b0);
  endtask
  task automatic settle(input logic [6:0] conc);
    concentration_i <= conc;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk(8'(comm_ok), 8'h01);
    chk(8'(fault_relay_o), 8'h01);
    hold(1'b1, 1'b0);
    chk(8'(program_mode_o), 8'h00);
    hold(1'b0, 1'b1);
    chk({4'h0, program_mode_o, menu_item_o}, 8'h08);
    first_magnet_switch_i <= 1'b1;
    repeat (HOLD + 4) @(posedge mclk_i);
    first_magnet_switch_i <= 1'b0;
    n = 0;
    last = 4'hf;
    for (int i = 0; i < 200 && !(n > 0 && message_o === 3'h1); i++) begin
      @(posedge mclk_i);
      if (message_o === 3'h2 && status_index_o !== last) begin
        chk(8'(status_index_o), {4'h0, last + 4'h1});
        last = status_index_o;
        n++;
      end
    end
    chk(8'(n), 8'd14);
    chk({2'h0, message_o, menu_item_o}, 8'h08);
    foreach (items[i]) begin
      tap(1'b0, 1'b1);
      chk(8'(menu_item_o), 8'(items[i]));
    end
    go_item(3'h1);
    hold(1'b1, 1'b0);
    chk(display_value_o, 8'h32);
    repeat (52) tap(1'b0, 1'b1);
    chk(display_value_o, 8'h64);
    tap(1'b1, 1'b0);
    hold(1'b0, 1'b1);
    chk({span_level_o, 1'b0}, {7'h63, 1'b0});
    chk(8'(menu_item_o), 8'h01);
    go_item(3'h3);
    hold(1'b0, 1'b1);
    tap(1'b1, 1'b0);
    chk(display_value_o, 8'h01);
    repeat (2) tap(1'b0, 1'b1);
    hold(1'b0, 1'b1);
    chk(8'(slave_address_o), 8'h03);
    go_item(3'h2);
    hold(1'b1, 1'b0);
    repeat (10) tap(1'b1, 1'b0);
    hold(1'b1, 1'b0);
    chk({2'h0, setup_step_o, message_o}, 8'h0c);
    hold(1'b1, 1'b0);
    tap(1'b0, 1'b1);
    tap(1'b1, 1'b0);
    hold(1'b1, 1'b0);
    chk(8'(setup_step_o), 8'h02);
    hold(1'b1, 1'b0);
    chk({menu_item_o, 1'b0, relay_cfg_o[3:0]}, 8'h41);
    chk(8'(alarm_one_threshold_o), 8'h0a);
    go_item(3'h6);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b0);
    tap(1'b1, 1'b0);
    repeat (3) hold(1'b1, 1'b0);
    go_item(3'h7);
    hold(1'b1, 1'b0);
    chk(8'(setup_step_o), 8'h03);
    repeat (2) hold(1'b1, 1'b0);
    chk(8'(menu_item_o), 8'h07);
    go_item(3'h5);
    hold(1'b1, 1'b0);
    chk({sim_active_o, 4'h0, message_o}, 8'h86);
    for (int i = 0; i < 1200 && sim_percent_o !== 7'h64; i++) @(posedge mclk_i);
    chk(8'(sim_percent_o), 8'h64);
    for (int i = 0; i < 1200 && sim_percent_o !== 7'h00; i++) @(posedge mclk_i);
    repeat (15) @(posedge mclk_i);
    chk(8'(sim_percent_o), 8'h01);
    repeat (IDLE + 20) @(posedge mclk_i);
    chk(8'(sim_active_o), 8'h01);
    hold(1'b0, 1'b1);
    chk({sim_active_o, 4'h0, menu_item_o}, 8'h05);
    repeat (IDLE + 10) @(posedge mclk_i);
    chk(8'(program_mode_o), 8'h00);
    settle(7'h09);
    chk({alarm_one_active_o, alarm_two_active_o}, 8'h01);
    settle(7'h0a);
    chk({alarm_one_active_o, alarm_one_relay_o}, 8'h03);
    settle(7'h29);
    chk({alarm_one_active_o, alarm_two_active_o}, 8'h02);
    settle(7'h28);
    chk({alarm_two_active_o, alarm_two_relay_o}, 8'h03);
    relay_reset_i <= 1'b1;
    settle(7'h05);
    chk({alarm_one_active_o, alarm_two_active_o}, 8'h01);
    relay_reset_i <= 1'b0;
    sensor_fault_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk({fault_active_o, fault_relay_o}, 8'h02);
    finish_test();
  end
endmodule // remote_alarm_menu_relay_ctrl_test
